// ---- bench/ctgl_logic_monitor.sv ----
// Purpose: bus and relay output checks on ctgl_logic
// Assumes: two-frequency variant, ports only
// Notes:   timer lengths are left to the bench
`timescale 1ns/1ns
module ctgl_logic_monitor (
    // Clock and reset
    input wire        clk,
    input wire        nrst,
    // Bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Relay side
    input wire        three_freq,
    input wire        trip_out,
    input wire        guard_out,
    input wire        lowlvl_out_n,
    input wire        cb_out,
    input wire        em_trip_pos,
    input wire        em_trip_neg,
    input wire        em_guard
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !trip_out && !guard_out && !cb_out && lowlvl_out_n && !em_trip_pos && !em_guard)
        else $error("relay output active after reset");
    a_cb_with_trip: assert property ($rose(trip_out) |-> cb_out)
        else $error("trip without checkback");
    a_em_pos_2f: assert property (!three_freq |-> em_trip_pos == trip_out && em_guard == guard_out)
        else $error("relay card differs from outputs");
    a_em_neg_2f: assert property (!three_freq |-> !em_trip_neg)
        else $error("negative drive in two-frequency mode");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule

bind ctgl_logic ctgl_logic_monitor mon_u (.*);

// ---- bench/ctgl_logic_tb.sv ----
// Purpose: self-checking bench for ctgl_logic
// Assumes: two-frequency variant, 10 clocks per ms
// Notes:   timer checks allow a tick plus pin latency
`timescale 1ns/1ns
module ctgl_logic_tb;
    localparam MS = 10;
    logic        clk = 1'h0, nrst = 1'h0, three_freq = 1'h0, rx_dtt_trip = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, noise_en = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0]  sw_bank1 = 8'h0, sw_bank2 = 8'h0, sw_bank3 = 8'h0;
    logic [1:0]  st = 2'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         rx_trip, rx_guard, rx_lowlvl, rx_noise;
    wire         trip_out, guard_out, lowlvl_out_n, cb_out, em_trip_pos, em_trip_neg, em_guard;
    int fails = 0, n_compared = 0, seed = 90074, cyc = 0, t, i, n;
    int hold_ms[4] = '{0, 10, 50, 100};
    int ubw_ms[4] = '{0, 150, 300, 500};
    int ll_ms[8] = '{0, 10, 15, 20, 40, 0, 0, 0};
    int llc[3] = '{1, 4, 2};

    ctgl_logic #(.CLKS_PER_MS(MS)) dut_u (.*);
    ctgl_rx_model rx_u (.*);

    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            fails++;
            end_of_test();
        end
    end

    function logic pick(input int k);
        pick = (k == 0) ? trip_out : (k == 1) ? guard_out : cb_out;
    endfunction
    task chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_rng(input string nm, input int e, input int g);
        n_compared++;
        if (g < e - 10 || g > e + 25) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task go(input logic [1:0] s, input int c);
        @(posedge clk);
        st <= s;
        repeat (c) @(posedge clk);
    endtask
    task wait_on(input int k, input int lim, output int r);
        r = 0;
        while (pick(k) !== 1'h1 && r < lim) begin
            @(negedge clk);
            r++;
        end
    endtask
    task cnt_hi(input int k, output int r);
        r = 0;
        while (pick(k) === 1'h1 && r < 8000) begin
            @(negedge clk);
            r++;
        end
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int w;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        w = 0;
        tb = 1'h0;
        while (!tb && w < 50) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            // Late bready lets the response wait a cycle
            if (w == 2) s_axi_bready <= 1'h1;
            w++;
        end
        s_axi_bready <= 1'h0;
        chk_eq("write response", {30'h0, er}, {30'h0, r});
        chk_eq("write answered", 32'h1, tb);
    endtask
    task axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [1:0] r;
        logic [31:0] d;
        int w;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        w = 0;
        tr = 1'h0;
        while (!tr && w < 50) begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'h0;
            if (w == 1) s_axi_rready <= 1'h1;
            w++;
        end
        s_axi_rready <= 1'h0;
        chk_eq("read data", ed, d);
        chk_eq("read response", {30'h0, er}, {30'h0, r});
        chk_eq("read answered", 32'h1, tr);
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        @(negedge clk);
        chk_eq("outputs idle", 32'h0, {trip_out, guard_out, cb_out});
        chk_eq("low level idle", 32'h1, lowlvl_out_n);
        axr(4'h0, 32'h1, 2'h0);
        axr(4'h4, 32'h0, 2'h0);
        axr(4'h8, 32'h0, 2'h2);
        axw(4'h4, 32'hFFFF, 2'h0);
        axw(4'hC, 32'h0, 2'h2);
        axr(4'h4, 32'h0, 2'h0);
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            // zero delay as an unblock installer would set
            n = (i == 0) ? 0 : (i == 1) ? 15 : $random(seed) & 15;
            sw_bank1 <= n[7:0];
            sw_bank2 <= {3'($random(seed)), 5'h0};
            sw_bank3 <= {3'h0, 5'($random(seed))};
            go(1, 200);
            go(2, 0);
            wait_on(0, 500, t);
            chk_rng("pre-trip delay", 2 * n * MS, t);
            chk_eq("checkback with trip", 32'h1, cb_out);
            go(1, 100);
        end
        $display("test pre-trip done");
        for (i = 0; i < 4; i++) begin
            sw_bank1 <= 8'(i * 80);
            sw_bank2 <= 8'h0;
            sw_bank3 <= 8'h0;
            go(2, 100);
            go(1, 0);
            cnt_hi(0, t);
            chk_rng("trip hold", hold_ms[i] * MS, t);
            go(1, 200);
            go(0, 0);
            cnt_hi(1, t);
            chk_rng("guard hold", hold_ms[i] * MS, t);
            go(1, 100);
        end
        $display("test holds done");
        for (i = 0; i < 3; i++) begin
            // trip hold left off for unblock use
            sw_bank1 <= 8'h0;
            sw_bank2 <= 8'(i + 1);
            sw_bank3 <= 8'(llc[i] * 32);
            noise_en <= i[0];
            go(1, 1500);
            go(3, 0);
            wait_on(0, 800, t);
            chk_rng("unblock start", ll_ms[llc[i]] * MS, t);
            chk_eq("low level out", 32'h0, lowlvl_out_n);
            cnt_hi(0, t);
            chk_rng("unblock window", ubw_ms[i + 1] * MS, t);
            axr(4'h4, 32'hE0, 2'h0);
            go(2, 300);
            chk_eq("locked trip", 32'h1, {trip_out, cb_out});
            go(1, 1500);
            axr(4'h4, 32'h8A, 2'h0);
        end
        $display("test unblock done");
        sw_bank2 <= 8'h05;
        noise_en <= 1'h1;
        go(1, 1500);
        go(3, 0);
        wait_on(0, 400, t);
        chk_rng("noise block", 400, t);
        go(1, 1500);
        noise_en <= 1'h0;
        $display("test noise done");
        sw_bank2 <= 8'h08;
        go(1, 1500);
        go(3, 200);
        go(2, 200);
        chk_eq("trip before guard", 32'h0, trip_out);
        go(1, 600);
        go(2, 200);
        chk_eq("short guard", 32'h0, trip_out);
        go(1, 1300);
        go(2, 200);
        chk_eq("guard returned", 32'h1, trip_out);
        axw(4'h0, 32'h0, 2'h0);
        chk_eq("relays held off", 32'h0, {trip_out, cb_out, em_trip_pos});
        axr(4'h0, 32'h0, 2'h0);
        axw(4'h0, 32'h1, 2'h0);
        go(1, 200);
        sw_bank2 <= 8'h10;
        go(1, 1500);
        go(2, 10500);
        go(3, 200);
        go(2, 200);
        chk_eq("override trip", 32'h1, trip_out);
        $display("test guard before trip done");
        end_of_test();
    end
endmodule

// ---- bench/ctgl_rx_model.sv ----
// Purpose: receiver front end seen by ctgl_logic
// Assumes: state set by the bench after a clock edge
// Notes:   pins are registered, so they move one clock late
`timescale 1ns/1ns
module ctgl_rx_model (
    // Clock
    input  wire       clk,
    // Channel: 0 quiet, 1 guard, 2 trip, 3 lost
    input  wire [1:0] st,
    input  wire       noise_en,
    // Receiver pins
    output reg        rx_trip = 1'h0,
    output reg        rx_guard = 1'h0,
    output reg        rx_lowlvl = 1'h0,
    output reg        rx_noise = 1'h0
);
    // Tones are exclusive; a lost channel carries neither
    always @(posedge clk) begin
        rx_guard <= (st == 2'h1);
        rx_trip <= (st == 2'h2);
        rx_lowlvl <= (st == 2'h3);
        rx_noise <= noise_en;
    end
endmodule

// ---- src/ctgl_defs.vh ----
// Purpose: shared constants of the carrier trip/guard decision logic
// Assumes: 100 MHz system clock, millisecond timebase
// Notes:   switch bank bit positions are zero based
`ifndef CTGL_DEFS_VH
`define CTGL_DEFS_VH

// Timebase
`define CTGL_CLK_PERIOD_NS 10
`define CTGL_MS_NS         1000000
`define CTGL_TW            11

// Decision timers in ms
`define CTGL_GBT_MS        11'd120
`define CTGL_TAG_MS        11'd120
`define CTGL_OVR_MS        11'd1000
`define CTGL_OVR_CLR_MS    11'd200
`define CTGL_HOLD_A_MS     11'd10
`define CTGL_HOLD_B_MS     11'd50
`define CTGL_HOLD_C_MS     11'd100
`define CTGL_UBW_A_MS      11'd150
`define CTGL_UBW_B_MS      11'd300
`define CTGL_UBW_C_MS      11'd500
`define CTGL_LL_A_MS       11'd10
`define CTGL_LL_B_MS       11'd15
`define CTGL_LL_C_MS       11'd20
`define CTGL_LL_D_MS       11'd40

// Switch positions, bank 1
`define CTGL_SW1_PRETRIP   0
`define CTGL_SW1_TRIPHOLD  4
`define CTGL_SW1_GUARDHOLD 6
// Bank 2
`define CTGL_SW2_UBWIN     0
`define CTGL_SW2_NOISEBLK  2
`define CTGL_SW2_GBT       3
// Bank 3
`define CTGL_SW3_LLDLY     5

// Register map
`define CTGL_REG_CTRL      4'h0
`define CTGL_REG_STATUS    4'h4
`define CTGL_CTRL_RST      1'h1
`define CTGL_RESP_OKAY     2'b00
`define CTGL_RESP_SLVERR   2'b10
`endif

// ---- src/ctgl_logic.v ----
// Purpose: trip/guard decision logic of a frequency-shift carrier receiver
// Assumes: switch banks and receiver indications are asynchronous pins
// Notes:   phase comparison and transfer-trip switch tables are not present
`timescale 1ns/1ns
`include "ctgl_defs.vh"

// Function
// - Trip output waits until trip has been present for the pre-trip delay.
// - Pre-trip delay is twice the four-switch binary count, zero to thirty ms.
// - Trip output is stretched by 10, 50 or 100 ms, or not.
// - Trip hold pair: open/open off, a 10, b 50, both 100 ms.
// - Guard output is stretched by 10, 50 or 100 ms, or not.
// - Guard hold pair: open/open off, a 10, b 50, both 100 ms.
// - Loss of channel trips for the unblock window unless disabled.
// - Window pair: open/open off, a 150, b 300, both 500 ms.
// - Noise blocks the unblock trip only when noise-block switch is closed.
// - Guard-before-trip needs 120 ms continuous guard before tripping.
// - Override waives guard return after more than one second of trip.
// - GBT pair: off, a on, b on with override, both unused.
// - Low-level delay postpones unblock start and the low-level output.
// - Delay selects: none, a 10, b 15, a+b 20, c 40 ms.
// - Two-frequency mode ignores the remaining switch positions.
// - Three-frequency mode adds a separate transfer-trip path.
// - Each path's trip drops only that path's guard output.
// - Three-frequency relay card trip: positive for transfer, negative for unblock.
// - Three-frequency unblock pre-trip runs zero to thirty ms, same coding.
// - Lost guard without trip within 120 ms locks tripping out.
// - After the unblock window, tripping waits for 120 ms of guard.
// - Holds act on outputs only, never on the decision logic.
// - Checkback asserts with trip, and alone for trip after lost channel.
module ctgl_logic #(
    parameter CLKS_PER_MS = `CTGL_MS_NS / `CTGL_CLK_PERIOD_NS,
    parameter DTT_PRE_MS  = 0,
    parameter DTT_TH_MS   = 0,
    parameter DTT_GH_MS   = 0
) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // AXI4-Lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receiver front end
    input  wire        rx_trip,
    input  wire        rx_dtt_trip,
    input  wire        rx_guard,
    input  wire        rx_lowlvl,
    input  wire        rx_noise,
    // Configuration switches and variant
    input  wire [7:0]  sw_bank1,
    input  wire [7:0]  sw_bank2,
    input  wire [7:0]  sw_bank3,
    input  wire        three_freq,
    // Relay outputs
    output reg         trip_out,
    output reg         guard_out,
    output reg         lowlvl_out_n,
    output reg         cb_out,
    output reg         em_trip_pos,
    output reg         em_trip_neg,
    output reg         em_guard
);
    localparam W  = `CTGL_TW;
    localparam NS = 30;

    // Pin synchroniser: change accepted when stages two and three agree
    reg [NS-1:0] s1_q;
    reg [NS-1:0] s2_q;
    reg [NS-1:0] s3_q;
    reg [NS-1:0] sv_q;
    reg [16:0]   tk_q;
    reg          tick_q;
    reg [W-1:0]  ll_q;
    reg          out_en_q;

    always @(posedge clk) begin
        if (!nrst) begin
            s1_q <= {NS{1'b0}};
            s2_q <= {NS{1'b0}};
            s3_q <= {NS{1'b0}};
            sv_q <= {NS{1'b0}};
        end else begin
            s1_q <= {three_freq, sw_bank3, sw_bank2, sw_bank1, rx_noise, rx_lowlvl, rx_guard, rx_dtt_trip, rx_trip};
            s2_q <= s1_q;
            s3_q <= s2_q;
            sv_q <= (s2_q & s3_q) | (sv_q & (s2_q | s3_q));
        end
    end

    wire       trip_s  = sv_q[0];
    wire       dtt_s   = sv_q[1];
    wire       guard_s = sv_q[2];
    wire       low_s   = sv_q[3];
    wire       noise_s = sv_q[4];
    wire [7:0] bank1   = sv_q[12:5];
    wire [7:0] bank2   = sv_q[20:13];
    wire [7:0] bank3   = sv_q[28:21];
    wire       tf_s    = sv_q[29];

    wire [3:0] pretrip_sel     = bank1[`CTGL_SW1_PRETRIP +: 4];
    wire       triphold_sel_a  = bank1[`CTGL_SW1_TRIPHOLD];
    wire       triphold_sel_b  = bank1[`CTGL_SW1_TRIPHOLD + 1];
    wire       guardhold_sel_a = bank1[`CTGL_SW1_GUARDHOLD];
    wire       guardhold_sel_b = bank1[`CTGL_SW1_GUARDHOLD + 1];
    wire       unblock_win_sel_a  = bank2[`CTGL_SW2_UBWIN];
    wire       unblock_win_sel_b  = bank2[`CTGL_SW2_UBWIN + 1];
    wire       noise_block_sel    = bank2[`CTGL_SW2_NOISEBLK];
    wire       gbt_sel_a          = bank2[`CTGL_SW2_GBT];
    wire       gbt_sel_b          = bank2[`CTGL_SW2_GBT + 1];
    wire       lowlvl_delay_sel_a = bank3[`CTGL_SW3_LLDLY];
    wire       lowlvl_delay_sel_b = bank3[`CTGL_SW3_LLDLY + 1];
    wire       lowlvl_delay_sel_c = bank3[`CTGL_SW3_LLDLY + 2];

    function [W-1:0] hold_ms;
        input a;
        input b;
        case ({b, a})
            2'b01:   hold_ms = `CTGL_HOLD_A_MS;
            2'b10:   hold_ms = `CTGL_HOLD_B_MS;
            2'b11:   hold_ms = `CTGL_HOLD_C_MS;
            default: hold_ms = {W{1'b0}};
        endcase
    endfunction

    function [W-1:0] ubw_ms;
        input a;
        input b;
        case ({b, a})
            2'b01:   ubw_ms = `CTGL_UBW_A_MS;
            2'b10:   ubw_ms = `CTGL_UBW_B_MS;
            2'b11:   ubw_ms = `CTGL_UBW_C_MS;
            default: ubw_ms = {W{1'b0}};
        endcase
    endfunction

    // low-level delay decode; unlisted codes fall back to none
    function [W-1:0] ll_ms;
        input [2:0] s;
        case (s)
            3'b001:  ll_ms = `CTGL_LL_A_MS;
            3'b010:  ll_ms = `CTGL_LL_B_MS;
            3'b011:  ll_ms = `CTGL_LL_C_MS;
            3'b100:  ll_ms = `CTGL_LL_D_MS;
            default: ll_ms = {W{1'b0}};
        endcase
    endfunction

    wire [W-1:0] pre_ms = {{(W-5){1'b0}}, pretrip_sel, 1'b0};
    wire gbt_on = gbt_sel_a ^ gbt_sel_b;
    wire ovr_on = gbt_sel_b && !gbt_sel_a;
    wire [W-1:0] lld_ms = ll_ms({lowlvl_delay_sel_c, lowlvl_delay_sel_b, lowlvl_delay_sel_a});

    // Millisecond timebase
    always @(posedge clk) begin
        if (!nrst) begin
            tk_q   <= 17'h00000;
            tick_q <= 1'b0;
        end else if (tk_q == CLKS_PER_MS[16:0] - 17'h00001) begin
            tk_q   <= 17'h00000;
            tick_q <= 1'b1;
        end else begin
            tk_q   <= tk_q + 17'h00001;
            tick_q <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!nrst)
            ll_q <= {W{1'b0}};
        else if (!low_s)
            ll_q <= {W{1'b0}};
        else if (tick_q && ll_q < lld_ms)
            ll_q <= ll_q + 1'b1;
    end
    wire low_del = low_s && (ll_q >= lld_ms);
    wire loc     = low_del && !guard_s;

    wire ub_trip;
    wire ub_guard;
    wire ub_cb;
    wire ub_lock;
    wire tt_trip;
    wire tt_guard;
    wire tt_cb;
    wire tt_lock;

    ctgl_path #(.W(W)) u_ub (
        .clk       (clk),
        .nrst      (nrst),
        .tick      (tick_q),
        .trip_in   (trip_s),
        .guard_in  (guard_s),
        .loc       (loc),
        .noise_blk (noise_block_sel && noise_s),
        .pre_ms    (pre_ms),
        .th_ms     (hold_ms(triphold_sel_a, triphold_sel_b)),
        .gh_ms     (hold_ms(guardhold_sel_a, guardhold_sel_b)),
        .ub_ms     (ubw_ms(unblock_win_sel_a, unblock_win_sel_b)),
        .gbt_on    (gbt_on),
        .ovr_on    (ovr_on),
        .trip_out  (ub_trip),
        .guard_out (ub_guard),
        .cb_out    (ub_cb),
        .lock_out  (ub_lock)
    );

    ctgl_path #(.W(W)) u_tt (
        .clk       (clk),
        .nrst      (nrst),
        .tick      (tick_q),
        .trip_in   (tf_s && dtt_s),
        .guard_in  (tf_s && guard_s),
        .loc       (tf_s && loc),
        .noise_blk (1'b0),
        .pre_ms    (DTT_PRE_MS[W-1:0]),
        .th_ms     (DTT_TH_MS[W-1:0]),
        .gh_ms     (DTT_GH_MS[W-1:0]),
        .ub_ms     ({W{1'b0}}),
        .gbt_on    (gbt_on),
        .ovr_on    (ovr_on),
        .trip_out  (tt_trip),
        .guard_out (tt_guard),
        .cb_out    (tt_cb),
        .lock_out  (tt_lock)
    );

    // Output stage; control bit lets software hold all relays but lowlvl_out_n off in test
    always @(posedge clk) begin
        if (!nrst) begin
            trip_out     <= 1'b0;
            guard_out    <= 1'b0;
            lowlvl_out_n <= 1'b1;
            cb_out       <= 1'b0;
            em_trip_pos  <= 1'b0;
            em_trip_neg  <= 1'b0;
            em_guard     <= 1'b0;
        end else begin
            trip_out     <= out_en_q && ub_trip;
            guard_out    <= out_en_q && ub_guard;
            lowlvl_out_n <= !low_del;
            cb_out       <= out_en_q && (ub_cb || tt_cb);
            em_trip_pos  <= out_en_q && (tf_s ? tt_trip : ub_trip);
            em_trip_neg  <= out_en_q && tf_s && ub_trip;
            em_guard     <= out_en_q && (tf_s ? tt_guard : ub_guard);
        end
    end

    // AXI4-Lite: address and data taken in either order, response after both
    reg        aw_q;
    reg        w_q;
    reg [3:0]  awa_q;
    reg [31:0] wd_q;
    reg [3:0]  ws_q;

    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire [31:0] status = {24'h000000, tt_lock, ub_lock, loc, cb_out,
                          guard_out, trip_out, em_guard, em_trip_pos};

    always @(posedge clk) begin
        if (!nrst) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awa_q        <= 4'h0;
            wd_q         <= 32'h00000000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CTGL_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `CTGL_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            out_en_q     <= `CTGL_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q  <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q  <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_q && w_q) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awa_q == `CTGL_REG_CTRL) begin
                    s_axi_bresp <= `CTGL_RESP_OKAY;
                    if (ws_q[0])
                        out_en_q <= wd_q[0];
                end else if (awa_q == `CTGL_REG_STATUS)
                    s_axi_bresp <= `CTGL_RESP_OKAY;
                else
                    s_axi_bresp <= `CTGL_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr == `CTGL_REG_CTRL) begin
                    s_axi_rdata <= {31'h00000000, out_en_q};
                    s_axi_rresp <= `CTGL_RESP_OKAY;
                end else if (s_axi_araddr == `CTGL_REG_STATUS) begin
                    s_axi_rdata <= status;
                    s_axi_rresp <= `CTGL_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CTGL_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// One decision path: pre-trip, guard-before-trip, trip-after-guard,
// unblock window, override, holds and checkback
module ctgl_path #(
    parameter W = `CTGL_TW
) (
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    input  wire         tick,
    // Receiver indications
    input  wire         trip_in,
    input  wire         guard_in,
    input  wire         loc,
    input  wire         noise_blk,
    // Settings in ms
    input  wire [W-1:0] pre_ms,
    input  wire [W-1:0] th_ms,
    input  wire [W-1:0] gh_ms,
    input  wire [W-1:0] ub_ms,
    input  wire         gbt_on,
    input  wire         ovr_on,
    // Outputs
    output reg          trip_out,
    output reg          guard_out,
    output reg          cb_out,
    output reg          lock_out
);
    reg [W-1:0] pt_q;
    reg [W-1:0] gd_q;
    reg [W-1:0] tag_q;
    reg [W-1:0] lt_q;
    reg [W-1:0] ub_q;
    reg [W-1:0] th_q;
    reg [W-1:0] gh_q;
    reg         lock_q;
    reg         ovr_q;
    reg         loc_q;
    reg         lock_d;

    wire trip_ok  = trip_in && (pt_q >= pre_ms);
    wire ub_act   = (ub_q != {W{1'b0}});
    wire loc_rise = loc && !loc_q;
    wire trip_int = (trip_ok && !lock_q) || (ub_act && !noise_blk);
    wire guard_eff = guard_in && !trip_int;

    always @* begin
        lock_d = lock_q;
        if (gd_q >= `CTGL_GBT_MS)
            lock_d = 1'b0;
        if (tick && ub_q == {{(W-1){1'b0}}, 1'b1} && loc)
            lock_d = 1'b1;
        if (tag_q >= `CTGL_TAG_MS && !ub_act && !ovr_q)
            lock_d = 1'b1;
        if (loc_rise && gbt_on && !ovr_q)
            lock_d = 1'b1;
    end

    always @(posedge clk) begin
        if (!nrst) begin
            pt_q      <= {W{1'b0}};
            gd_q      <= {W{1'b0}};
            tag_q     <= {W{1'b0}};
            lt_q      <= {W{1'b0}};
            ub_q      <= {W{1'b0}};
            th_q      <= {W{1'b0}};
            gh_q      <= {W{1'b0}};
            lock_q    <= 1'b0;
            ovr_q     <= 1'b0;
            loc_q     <= 1'b0;
            trip_out  <= 1'b0;
            guard_out <= 1'b0;
            cb_out    <= 1'b0;
            lock_out  <= 1'b0;
        end else begin
            loc_q  <= loc;
            lock_q <= lock_d;
            lock_out <= lock_d;
            if (!trip_in)
                pt_q <= {W{1'b0}};
            else if (tick && pt_q < pre_ms)
                pt_q <= pt_q + 1'b1;
            if (!guard_in)
                gd_q <= {W{1'b0}};
            else if (tick && gd_q < `CTGL_OVR_CLR_MS)
                gd_q <= gd_q + 1'b1;
            if (guard_in || trip_in)
                tag_q <= {W{1'b0}};
            else if (tick && tag_q < `CTGL_TAG_MS)
                tag_q <= tag_q + 1'b1;
            if (!trip_in)
                lt_q <= {W{1'b0}};
            else if (tick && lt_q <= `CTGL_OVR_MS)
                lt_q <= lt_q + 1'b1;
            if (ovr_on && lt_q > `CTGL_OVR_MS)
                ovr_q <= 1'b1;
            else if (gd_q >= `CTGL_OVR_CLR_MS || !ovr_on)
                ovr_q <= 1'b0;
            if (!loc)
                ub_q <= {W{1'b0}};
            else if (loc_rise && !lock_q)
                ub_q <= ub_ms;
            else if (tick && ub_act)
                ub_q <= ub_q - 1'b1;
            if (trip_int)
                th_q <= th_ms;
            else if (tick && th_q != {W{1'b0}})
                th_q <= th_q - 1'b1;
            if (guard_eff)
                gh_q <= gh_ms;
            else if (tick && gh_q != {W{1'b0}})
                gh_q <= gh_q - 1'b1;
            trip_out  <= trip_int || (th_q != {W{1'b0}});
            guard_out <= guard_eff || (gh_q != {W{1'b0}});
            cb_out    <= trip_int || trip_in;
        end
    end
endmodule
